// >>> shared/sds_pkg.sv
package sds_pkg;

  // ****************************************
  // register offsets (byte addresses)
  // ****************************************
  localparam logic [8:0] SDS_OFS_CTRL  = 9'h000;
  localparam logic [8:0] SDS_OFS_MODE  = 9'h004;
  localparam logic [8:0] SDS_OFS_RXD   = 9'h008;
  localparam logic [8:0] SDS_OFS_TXD   = 9'h00C;
  localparam logic [8:0] SDS_OFS_STAT  = 9'h010;
  localparam logic [8:0] SDS_OFS_IEN   = 9'h014;
  localparam logic [8:0] SDS_OFS_IDIS  = 9'h018;
  localparam logic [8:0] SDS_OFS_IMSK  = 9'h01C;
  localparam logic [8:0] SDS_OFS_CSR0  = 9'h030;
  localparam logic [8:0] SDS_OFS_CSR3  = 9'h03C;
  localparam logic [8:0] SDS_OFS_RXCNT = 9'h104;
  localparam logic [8:0] SDS_OFS_TXCNT = 9'h10C;
  localparam logic [8:0] SDS_OFS_RXNXT = 9'h114;
  localparam logic [8:0] SDS_OFS_TXNXT = 9'h11C;

  // ****************************************
  // field positions and reset values
  // ****************************************
  localparam int SDS_CTRL_EN    = 0;
  localparam int SDS_CTRL_DIS   = 1;
  localparam int SDS_CTRL_SWRST = 7;
  localparam logic [31:0] SDS_MODE_WMASK = 32'hFF0F009F;
  localparam logic [31:0] SDS_CSR_WMASK  = 32'hFFFFFFF3;
  localparam logic [7:0]  SDS_IMSK_RST   = 8'h00;
  localparam logic        SDS_BLK_RST    = 1'b1;
  localparam logic [3:0]  SDS_CS_IDLE    = 4'hF;

  // ****************************************
  // timing counts in interface ticks and clocks, and the base character length in bits
  // ****************************************
  localparam logic [4:0]  SDS_PRESCALE_LAST = 5'h1F;
  localparam logic [15:0] SDS_GAP_MIN_TICKS = 16'h0004;
  localparam int          SDS_GAP_UNIT_LOG2 = 5;
  localparam logic [7:0]  SDS_BAUD_MIN      = 8'h02;
  localparam logic [4:0]  SDS_CHAR_BASE     = 5'h08;

  // ****************************************
  // types
  // ****************************************
  typedef struct packed {
    logic [7:0] cs_gap;
    logic [3:0] rsv2;
    logic [3:0] select_code;
    logic [7:0] rsv1;
    logic       loopback;
    logic [1:0] rsv0;
    logic       fault_off;
    logic       prescale_by_32;
    logic       select_decode_on;
    logic       select_mode_variable;
    logic       master_select;
  } sds_mode_t;

  typedef struct packed {
    logic [7:0] gap_delay;
    logic [7:0] lead_delay;
    logic [7:0] baud_divisor;
    logic [3:0] char_len;
    logic [1:0] rsv;
    logic       clock_edge_phase;
    logic       clock_idle_level;
  } sds_csr_t;

  typedef struct packed {
    logic       sclk;
    logic       mosi;
    logic       miso;
    logic       cs0_n;
  } sds_pin_in_t;

  typedef struct packed {
    logic       sclk;
    logic       sclk_oe;
    logic       mosi;
    logic       mosi_oe;
    logic       miso;
    logic       miso_oe;
    logic [3:0] select_pins_n;
    logic       select_pins_oe;
  } sds_pin_out_t;

  typedef enum logic [2:0] {
    SDS_IDLE,
    SDS_LEAD,
    SDS_SHIFT,
    SDS_GAP,
    SDS_SLAVE
  } sds_state_t;

endpackage : sds_pkg

// >>> hdl/sds_spi.sv
module sds_spi
  import sds_pkg::*;
(
  // clock and reset
  input  wire logic         clk_i,
  input  wire logic         rstn_i,
  // wishbone slave
  input  wire logic         wb_cyc_i,
  input  wire logic         wb_stb_i,
  input  wire logic         wb_we_i,
  input  wire logic [8:0]   wb_adr_i,
  input  wire logic [3:0]   wb_sel_i,
  input  wire logic [31:0]  wb_dat_i,
  output logic      [31:0]  wb_dat_o,
  output logic              wb_ack_o,
  // serial pins
  input  wire sds_pin_in_t  pins_i,
  output sds_pin_out_t      pins_o,
  // interrupt
  output logic              irq_o
);

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic hit(input logic [8:0] a, input logic [8:0] ofs);
    hit = (a[8:2] == ofs[8:2]);
  endfunction : hit

  function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] d,
                                         input logic [3:0] sel);
    logic [31:0] bm;
    bm = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
    wmerge = (old & ~bm) | (d & bm);
  endfunction : wmerge

  function automatic logic [1:0] csr_index(input logic [3:0] code, input logic dec);
    if (dec) begin
      csr_index = code[3:2];
    end else if (!code[0]) begin
      csr_index = 2'h0;
    end else if (!code[1]) begin
      csr_index = 2'h1;
    end else if (!code[2]) begin
      csr_index = 2'h2;
    end else begin
      csr_index = 2'h3;
    end
  endfunction : csr_index

  function automatic logic [3:0] cs_pins(input logic [3:0] code, input logic dec);
    if (dec) begin
      cs_pins = code;
    end else if (!code[0]) begin
      cs_pins = 4'hE;
    end else if (!code[1]) begin
      cs_pins = 4'hD;
    end else if (!code[2]) begin
      cs_pins = 4'hB;
    end else begin
      cs_pins = 4'h7;
    end
  endfunction : cs_pins

  // ****************************************
  // bus slave
  // ****************************************
  logic         req;
  logic         ack_reg;
  logic         wr_acc;
  logic         rd_acc;
  logic [31:0]  wdat;
  logic [31:0]  dat_reg;
  logic [31:0]  rd_mux;
  logic         rst;
  logic         swrst;

  assign req    = wb_cyc_i && wb_stb_i;
  assign wr_acc = req && ack_reg && wb_we_i;
  assign rd_acc = req && ack_reg && !wb_we_i;
  assign wdat   = wmerge(32'h0000_0000, wb_dat_i, wb_sel_i);
  assign swrst  = wr_acc && hit(wb_adr_i, SDS_OFS_CTRL) && wdat[SDS_CTRL_SWRST];
  // soft reset acts like the pin reset on everything
  assign rst    = !rstn_i || swrst;
  assign wb_ack_o = ack_reg;
  assign wb_dat_o = dat_reg;

  always_ff @(posedge clk_i) begin
    if (rst) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= req && !ack_reg;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst) begin
      dat_reg <= 32'h0000_0000;
    end else if (req && !ack_reg) begin
      dat_reg <= rd_mux;
    end
  end

  // ****************************************
  // registers
  // ****************************************
  sds_mode_t    mode_reg;
  sds_csr_t     csr_reg [4];
  logic [15:0]  send_char_reg;
  logic [3:0]   tx_code_reg;
  logic [15:0]  rx_data_reg;
  logic [3:0]   rx_code_reg;
  logic [7:0]   imsk_reg;
  logic         enabled_reg;
  logic         rx_full_flag_reg;
  logic         tx_empty_flag_reg;
  logic         mode_fault_flag_reg;
  logic         overrun_flag_reg;
  logic         irq_reg;
  logic [15:0]  cnt_reg [2];
  logic [15:0]  nxt_reg [2];
  logic         blk_reg [2];
  logic [7:0]   flags;
  logic [31:0]  status;
  logic         wr_txd;
  logic         rd_rxd;
  logic         rd_stat;
  logic         cmd_en;
  logic         cmd_dis;
  logic         fault;
  logic         done;
  logic         load;
  logic [15:0]  rxs_nx;
  logic [3:0]   cs_reg;

  assign wr_txd  = wr_acc && hit(wb_adr_i, SDS_OFS_TXD);
  assign rd_rxd  = rd_acc && hit(wb_adr_i, SDS_OFS_RXD);
  assign rd_stat = rd_acc && hit(wb_adr_i, SDS_OFS_STAT);
  assign cmd_en  = wr_acc && hit(wb_adr_i, SDS_OFS_CTRL) && wdat[SDS_CTRL_EN];
  assign cmd_dis = wr_acc && hit(wb_adr_i, SDS_OFS_CTRL) && wdat[SDS_CTRL_DIS];

  assign flags = {(cnt_reg[1] == 16'h0000) && (nxt_reg[1] == 16'h0000),
                  (cnt_reg[0] == 16'h0000) && (nxt_reg[0] == 16'h0000),
                  blk_reg[1], blk_reg[0], overrun_flag_reg, mode_fault_flag_reg,
                  tx_empty_flag_reg, rx_full_flag_reg};
  assign status = {15'h0000, enabled_reg, 8'h00, flags};

  always_comb begin
    rd_mux = 32'h0000_0000;
    if (hit(wb_adr_i, SDS_OFS_MODE)) begin
      rd_mux = mode_reg;
    end else if (hit(wb_adr_i, SDS_OFS_RXD)) begin
      rd_mux = {12'h000, rx_code_reg, rx_data_reg};
    end else if (hit(wb_adr_i, SDS_OFS_STAT)) begin
      rd_mux = status;
    end else if (hit(wb_adr_i, SDS_OFS_IMSK)) begin
      rd_mux = {24'h000000, imsk_reg};
    end else if (wb_adr_i[8:4] == SDS_OFS_CSR0[8:4]) begin
      rd_mux = csr_reg[wb_adr_i[3:2]];
    end else if (hit(wb_adr_i, SDS_OFS_RXCNT)) begin
      rd_mux = {16'h0000, cnt_reg[0]};
    end else if (hit(wb_adr_i, SDS_OFS_TXCNT)) begin
      rd_mux = {16'h0000, cnt_reg[1]};
    end else if (hit(wb_adr_i, SDS_OFS_RXNXT)) begin
      rd_mux = {16'h0000, nxt_reg[0]};
    end else if (hit(wb_adr_i, SDS_OFS_TXNXT)) begin
      rd_mux = {16'h0000, nxt_reg[1]};
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst) begin
      mode_reg <= '0;
      for (int i = 0; i < 4; i++) begin
        csr_reg[i] <= '0;
      end
    end else if (wr_acc) begin
      if (hit(wb_adr_i, SDS_OFS_MODE)) begin
        mode_reg <= wmerge(mode_reg, wb_dat_i & SDS_MODE_WMASK, wb_sel_i);
      end
      if (wb_adr_i[8:4] == SDS_OFS_CSR0[8:4]) begin
        csr_reg[wb_adr_i[3:2]] <= wmerge(csr_reg[wb_adr_i[3:2]],
                                         wb_dat_i & SDS_CSR_WMASK, wb_sel_i);
      end
    end
  end

  logic [31:0]  txd_merged;
  assign txd_merged = wmerge({12'h000, tx_code_reg, send_char_reg}, wb_dat_i, wb_sel_i);

  // transmit holding word with its select code
  always_ff @(posedge clk_i) begin
    if (rst) begin
      send_char_reg <= 16'h0000;
      tx_code_reg   <= 4'h0;
    end else if (wr_txd) begin
      send_char_reg <= txd_merged[15:0];
      tx_code_reg   <= txd_merged[19:16];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst) begin
      imsk_reg <= SDS_IMSK_RST;
    end else if (wr_acc && hit(wb_adr_i, SDS_OFS_IEN)) begin
      imsk_reg <= imsk_reg | wdat[7:0];
    end else if (wr_acc && hit(wb_adr_i, SDS_OFS_IDIS)) begin
      imsk_reg <= imsk_reg & ~wdat[7:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= |(flags & imsk_reg);
    end
  end
  assign irq_o = irq_reg;

  always_ff @(posedge clk_i) begin
    if (rst) begin
      enabled_reg <= 1'b0;
    end else if (fault || cmd_dis) begin
      enabled_reg <= 1'b0;
    end else if (cmd_en) begin
      enabled_reg <= 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst) begin
      rx_full_flag_reg    <= 1'b0;
      overrun_flag_reg    <= 1'b0;
      mode_fault_flag_reg <= 1'b0;
    end else begin
      if (done) begin
        rx_full_flag_reg <= 1'b1;
      end else if (rd_rxd) begin
        rx_full_flag_reg <= 1'b0;
      end
      if (done && rx_full_flag_reg && !rd_rxd) begin
        overrun_flag_reg <= 1'b1;
      end else if (rd_stat) begin
        overrun_flag_reg <= 1'b0;
      end
      if (fault) begin
        mode_fault_flag_reg <= 1'b1;
      end else if (rd_stat) begin
        mode_fault_flag_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst || fault || cmd_dis) begin
      tx_empty_flag_reg <= 1'b0;
    end else if (load || cmd_en) begin
      tx_empty_flag_reg <= 1'b1;
    end else if (wr_txd) begin
      tx_empty_flag_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst) begin
      rx_data_reg <= 16'h0000;
      rx_code_reg <= 4'h0;
    end else if (done) begin
      rx_data_reg <= rxs_nx;
      rx_code_reg <= mode_reg.master_select ? cs_reg : 4'h0;
    end
  end

  // ****************************************
  // dma counters, 0 receive, 1 transmit
  // ****************************************
  for (genvar c = 0; c < 2; c++) begin : g_dma
    logic ev;
    logic wr_cnt;
    logic wr_nxt;
    assign ev     = (c == 0) ? done : load;
    assign wr_cnt = wr_acc && hit(wb_adr_i, (c == 0) ? SDS_OFS_RXCNT : SDS_OFS_TXCNT);
    assign wr_nxt = wr_acc && hit(wb_adr_i, (c == 0) ? SDS_OFS_RXNXT : SDS_OFS_TXNXT);

    always_ff @(posedge clk_i) begin
      if (rst) begin
        cnt_reg[c] <= 16'h0000;
        nxt_reg[c] <= 16'h0000;
      end else begin
        if (wr_cnt) begin
          cnt_reg[c] <= wdat[15:0] | (cnt_reg[c] & ~{{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}});
        end else if (ev && cnt_reg[c] == 16'h0001 && nxt_reg[c] != 16'h0000) begin
          cnt_reg[c] <= nxt_reg[c];
        end else if (ev && cnt_reg[c] != 16'h0000) begin
          cnt_reg[c] <= cnt_reg[c] - 16'h0001;
        end
        if (wr_nxt) begin
          nxt_reg[c] <= wdat[15:0] | (nxt_reg[c] & ~{{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}});
        end else if (!wr_cnt && ev && cnt_reg[c] == 16'h0001) begin
          nxt_reg[c] <= 16'h0000;
        end
      end
    end

    // block done, reaching zero wins over a count write
    always_ff @(posedge clk_i) begin
      if (rst) begin
        blk_reg[c] <= SDS_BLK_RST;
      end else if (ev && cnt_reg[c] == 16'h0001) begin
        blk_reg[c] <= 1'b1;
      end else if (wr_cnt || wr_nxt) begin
        blk_reg[c] <= 1'b0;
      end
    end
  end

  // ****************************************
  // pin synchronisers
  // ****************************************
  sds_pin_in_t  pin_meta_reg;
  sds_pin_in_t  pin_sync_reg;
  logic         sclk_prev_reg;

  always_ff @(posedge clk_i) begin
    if (rst) begin
      pin_meta_reg  <= '1;
      pin_sync_reg  <= '1;
      sclk_prev_reg <= 1'b1;
    end else begin
      pin_meta_reg  <= pins_i;
      pin_sync_reg  <= pin_meta_reg;
      sclk_prev_reg <= pin_sync_reg.sclk;
    end
  end

  // ****************************************
  // serializer
  // ****************************************
  sds_state_t   state_reg;
  sds_csr_t     cur_reg;
  logic [4:0]   pre_reg;
  logic [15:0]  timer_reg;
  logic [15:0]  hp_reg;
  logic [4:0]   edge_reg;
  logic [15:0]  txs_reg;
  logic [15:0]  rxs_reg;
  logic         out_bit_reg;
  logic         sclk_reg;
  logic         tick;
  logic [3:0]   pick_code;
  sds_csr_t     pick;
  logic [4:0]   nbits;
  logic [15:0]  aligned;
  logic         start_m;
  logic         start_s;
  logic         edge_fire;
  logic         capture;
  logic         in_bit;
  logic         last;
  logic [15:0]  src;
  logic [1:0]   own_hi_reg;

  always_ff @(posedge clk_i) begin
    if (rst) begin
      pre_reg <= 5'h00;
    end else begin
      pre_reg <= pre_reg + 5'h01;
    end
  end
  assign tick = !mode_reg.prescale_by_32 || (pre_reg == SDS_PRESCALE_LAST);

  assign pick_code = mode_reg.select_mode_variable ? tx_code_reg : mode_reg.select_code;
  assign pick      = mode_reg.master_select ?
                     csr_reg[csr_index(pick_code, mode_reg.select_decode_on)] : csr_reg[0];
  assign nbits     = SDS_CHAR_BASE + {1'b0, pick.char_len};
  // only the low bits of the word go out, msb first
  assign src       = start_s && tx_empty_flag_reg ? 16'h0000 : send_char_reg;
  assign aligned   = src << (5'h10 - nbits);
  // divisor below two blocks every master transfer
  assign start_m   = enabled_reg && mode_reg.master_select && !tx_empty_flag_reg
                     && !wr_txd && (pick.baud_divisor >= SDS_BAUD_MIN);
  assign start_s   = enabled_reg && !mode_reg.master_select && !pin_sync_reg.cs0_n;
  assign load      = (state_reg == SDS_IDLE) && !tx_empty_flag_reg && !wr_txd
                     && (start_m || start_s);

  assign edge_fire = ((state_reg == SDS_SHIFT) && tick && (hp_reg <= 16'h0001))
                     || ((state_reg == SDS_SLAVE) && (pin_sync_reg.sclk != sclk_prev_reg));
  // even edges lead; phase one captures on them
  assign capture   = (!edge_reg[0]) == cur_reg.clock_edge_phase;
  assign in_bit    = !mode_reg.master_select ? pin_sync_reg.mosi :
                     (mode_reg.loopback ? out_bit_reg : pin_sync_reg.miso);
  assign last      = {1'b0, edge_reg} == ({SDS_CHAR_BASE + {1'b0, cur_reg.char_len}, 1'b0}
                     - 6'h01);
  assign rxs_nx    = (edge_fire && capture) ? {rxs_reg[14:0], in_bit} : rxs_reg;
  assign done      = edge_fire && last;
  // low on select zero while this end holds it high
  assign fault     = enabled_reg && mode_reg.master_select && !mode_reg.fault_off
                     && !pin_sync_reg.cs0_n && cs_reg[0] && (&own_hi_reg);

  // own select drive reaches the synchroniser two clocks late; no false fault
  always_ff @(posedge clk_i) begin
    if (rst) begin
      own_hi_reg <= 2'h3;
    end else begin
      own_hi_reg <= {own_hi_reg[0], cs_reg[0]};
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst) begin
      state_reg   <= SDS_IDLE;
      cur_reg     <= '0;
      timer_reg   <= 16'h0000;
      hp_reg      <= 16'h0000;
      edge_reg    <= 5'h00;
      txs_reg     <= 16'h0000;
      rxs_reg     <= 16'h0000;
      out_bit_reg <= 1'b0;
      sclk_reg    <= 1'b0;
      cs_reg      <= SDS_CS_IDLE;
    end else begin
      unique case (state_reg)
        SDS_IDLE: begin
          // idle level of the serial clock
          sclk_reg <= pick.clock_idle_level;
          edge_reg <= 5'h00;
          rxs_reg  <= 16'h0000;
          if (start_m || start_s) begin
            cur_reg     <= pick;
            txs_reg     <= pick.clock_edge_phase ? (aligned << 1) : aligned;
            out_bit_reg <= pick.clock_edge_phase ? aligned[15] : out_bit_reg;
          end
          if (start_m) begin
            cs_reg    <= cs_pins(pick_code, mode_reg.select_decode_on);
            // lead delay, half period when zero
            timer_reg <= (pick.lead_delay == 8'h00) ? {8'h00, pick.baud_divisor}
                                                     : {8'h00, pick.lead_delay};
            state_reg <= SDS_LEAD;
          end else if (start_s) begin
            state_reg <= SDS_SLAVE;
          end else begin
            // a pending word keeps the select for the next one
            cs_reg <= SDS_CS_IDLE;
          end
        end
        SDS_LEAD: begin
          if (tick) begin
            timer_reg <= timer_reg - 16'h0001;
            if (timer_reg <= 16'h0001) begin
              hp_reg    <= {8'h00, cur_reg.baud_divisor};
              state_reg <= SDS_SHIFT;
            end
          end
        end
        SDS_SHIFT: begin
          if (tick) begin
            hp_reg <= (hp_reg <= 16'h0001) ? {8'h00, cur_reg.baud_divisor}
                                           : hp_reg - 16'h0001;
          end
          if (edge_fire) begin
            sclk_reg <= !sclk_reg;
            if (last) begin
              timer_reg <= (cur_reg.gap_delay == 8'h00) ? SDS_GAP_MIN_TICKS
                           : {3'h0, cur_reg.gap_delay, {SDS_GAP_UNIT_LOG2{1'b0}}};
              state_reg <= SDS_GAP;
            end
          end
        end
        SDS_GAP: begin
          if (tick) begin
            timer_reg <= timer_reg - 16'h0001;
            if (timer_reg <= 16'h0001) begin
              state_reg <= SDS_IDLE;
            end
          end
        end
        SDS_SLAVE: begin
          // deselect mid-character abandons it
          if (pin_sync_reg.cs0_n || done) begin
            state_reg <= SDS_IDLE;
          end
        end
      endcase
      if (edge_fire) begin
        edge_reg <= edge_reg + 5'h01;
        rxs_reg  <= rxs_nx;
        if (!capture) begin
          out_bit_reg <= txs_reg[15];
          txs_reg     <= txs_reg << 1;
        end
      end
    end
  end

  // ****************************************
  // pin drive
  // ****************************************
  logic drive_m;
  assign drive_m = mode_reg.master_select && (enabled_reg || state_reg != SDS_IDLE);

  always_comb begin
    pins_o                = '0;
    pins_o.sclk           = sclk_reg;
    pins_o.sclk_oe        = drive_m;
    pins_o.mosi           = out_bit_reg;
    pins_o.mosi_oe        = drive_m;
    pins_o.miso           = out_bit_reg;
    pins_o.miso_oe        = (state_reg == SDS_SLAVE);
    pins_o.select_pins_n  = cs_reg;
    pins_o.select_pins_oe = drive_m;
  end

endmodule : sds_spi

// >>> sim/sds_chk_properties.sv
// ****
// bus and pin checker
// ****
module sds_chk
  import sds_pkg::*;
(
  // bus
  input wire logic         clk_i,
  input wire logic         rstn_i,
  input wire logic         wb_cyc_i,
  input wire logic         wb_stb_i,
  input wire logic         wb_we_i,
  input wire logic [8:0]   wb_adr_i,
  input wire logic [31:0]  wb_dat_i,
  input wire logic [31:0]  wb_dat_o,
  input wire logic         wb_ack_o,
  // pins
  input wire sds_pin_out_t pins_o,
  input wire logic         irq_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] m_reg;
  wire        w = wb_ack_o && wb_we_i;
  // mirror of the mask, full byte enables assumed
  always_ff @(posedge clk_i) begin
    if (!rstn_i) m_reg <= SDS_IMSK_RST;
    else if (w && wb_adr_i == SDS_OFS_IEN) m_reg <= m_reg | wb_dat_i[7:0];
    else if (w && wb_adr_i == SDS_OFS_IDIS) m_reg <= m_reg & ~wb_dat_i[7:0];
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  sequence s_req; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
  sequence s_rd(a); wb_ack_o && !wb_we_i && wb_adr_i == a; endsequence
  property p_ack; s_req |=> wb_ack_o; endproperty
  a_ack: assert property (p_ack) else $error("no ack");
  property p_one; wb_ack_o |=> !wb_ack_o; endproperty
  a_one: assert property (p_one) else $error("long ack");
  property p_idle; !(wb_cyc_i && wb_stb_i) |=> !wb_ack_o; endproperty
  a_idle: assert property (p_idle) else $error("stray ack");
  property p_imsk; s_rd(SDS_OFS_IMSK) |-> wb_dat_o[7:0] == m_reg; endproperty
  a_imsk: assert property (p_imsk) else $error("mask view wrong");
  property p_irq; irq_o |-> (m_reg | $past(m_reg) | $past(m_reg, 2)) != 8'h00; endproperty
  a_irq: assert property (p_irq) else $error("irq while all masked");
  property p_wo; s_rd(SDS_OFS_TXD) |-> wb_dat_o == 32'h0; endproperty
  a_wo: assert property (p_wo) else $error("tx data reads back");
  property p_rst; $rose(rstn_i) |-> !pins_o.sclk && pins_o.select_pins_n == SDS_CS_IDLE;
  endproperty
  a_rst: assert property (p_rst) else $error("pins not idle after reset");
  property p_lead; pins_o.sclk_oe && $stable(pins_o.sclk_oe) && $changed(pins_o.sclk)
    |-> pins_o.select_pins_n != SDS_CS_IDLE; endproperty
  a_lead: assert property (p_lead) else $error("clock edge without select");
endmodule : sds_chk

bind sds_spi sds_chk sds_chk_inst (.clk_i(clk_i), .rstn_i(rstn_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pins_o(pins_o), .irq_o(irq_o));

// >>> sim/sds_slave_model.sv
// ****
// serial peripheral and foreign master
// ****
module sds_slave_model (
  // inputs
  input  wire logic       clk_i,
  input  wire logic [3:0] sel_n_i,
  input  wire logic       sel_oe_i,
  input  wire logic       fault_i,
  // outputs
  output logic            miso_o,
  output logic            cs0_n_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic flip_reg = 1'b0;
  // unselected line toggles so stale data never looks valid
  always_ff @(posedge clk_i) flip_reg <= ~flip_reg;
  assign miso_o  = (sel_n_i != 4'hF) ? 1'b1 : flip_reg;
  // pull-up on select zero, foreign master may pull it low
  assign cs0_n_o = fault_i ? 1'b0 : (sel_oe_i ? sel_n_i[0] : 1'b1);
endmodule : sds_slave_model

// >>> sim/testbench.sv
// ****
// register and transfer bench
// ****
module testbench import sds_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic [8:0] wa; logic [31:0] wd; logic [8:0] ra; logic [31:0] ex;} sds_row_t;
  logic         clk_i = 1'b0, rstn_i = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, fault = 1'b0;
  logic [8:0]   adr = 9'h000;
  logic [31:0]  dat = 32'h0, rdo, rd;
  logic         ack, irq;
  wire sds_pin_in_t pin_in;
  sds_pin_out_t pin_out;
  int           n_fail = 0, n_tests = 0, k;
  sds_row_t     rows [8] = '{
    '{SDS_OFS_CSR0 + 9'h004, 32'hFFFFFFFF, SDS_OFS_CSR0 + 9'h004, 32'hFFFFFFF3},
    '{SDS_OFS_CSR3, 32'h12345678, SDS_OFS_CSR3, 32'h12345670},
    '{SDS_OFS_IEN, 32'h00000005, SDS_OFS_IMSK, 32'h00000005},
    '{SDS_OFS_IDIS, 32'h00000001, SDS_OFS_IMSK, 32'h00000004},
    '{SDS_OFS_IEN, 32'h00000000, SDS_OFS_IMSK, 32'h00000004},
    '{9'h020, 32'hFFFFFFFF, 9'h020, 32'h00000000},
    '{SDS_OFS_TXCNT, 32'h00000010, SDS_OFS_STAT, 32'h00000050},
    '{SDS_OFS_RXCNT, 32'h00000010, SDS_OFS_STAT, 32'h00000000}};
  always #2 clk_i = ~clk_i;
  assign pin_in.sclk = pin_out.sclk_oe & pin_out.sclk;
  assign pin_in.mosi = pin_out.mosi_oe & pin_out.mosi;
  sds_spi sds_spi_inst (.clk_i(clk_i), .rstn_i(rstn_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(rdo),
    .wb_ack_o(ack), .pins_i(pin_in), .pins_o(pin_out), .irq_o(irq));
  sds_slave_model sds_slave_model_inst (.clk_i(clk_i), .sel_n_i(pin_out.select_pins_n),
    .sel_oe_i(pin_out.select_pins_oe), .fault_i(fault), .miso_o(pin_in.miso),
    .cs0_n_o(pin_in.cs0_n));
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : end_of_test
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
      n_fail++;
    end
  endtask : chk
  task automatic wb(input logic w, input logic [8:0] a, input logic [31:0] d);
    int i;
    @(posedge clk_i);
    {cyc, stb, we, adr, dat} <= {2'b11, w, a, d};
    for (i = 0; i < 20 && ack !== 1'b1; i++) @(posedge clk_i);
    if (i == 20) begin
      n_fail++;
      end_of_test();
    end
    rd = rdo;
    {cyc, stb} <= 2'b00;
  endtask : wb
  task automatic rdx(input logic [8:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask : rdx
  // one word out, then wait for select to rise again
  task automatic xfer(input logic [31:0] d);
    int i;
    wb(1'b1, SDS_OFS_TXD, d);
    for (i = 0; i < 9000 && pin_out.select_pins_n === SDS_CS_IDLE; i++) @(posedge clk_i);
    for (; i < 9000 && pin_out.select_pins_n !== SDS_CS_IDLE; i++) @(posedge clk_i);
    if (i == 9000) begin
      n_fail++;
      end_of_test();
    end
  endtask : xfer
  initial begin
    repeat (2) @(posedge clk_i);
    rstn_i <= 1'b1;
    foreach (rows[r]) begin
      wb(1'b1, rows[r].wa, rows[r].wd);
      rdx(rows[r].ra, rows[r].ex);
    end
    wb(1'b1, SDS_OFS_CSR0, 32'h00000200);
    wb(1'b1, SDS_OFS_CSR0 + 9'h008, 32'h00000280);
    wb(1'b1, SDS_OFS_MODE, 32'h000E0001);
    wb(1'b1, SDS_OFS_CTRL, 32'h00000001);
    rdx(SDS_OFS_STAT, 32'h00010002);
    xfer(32'h000000A5);
    rdx(SDS_OFS_RXD, 32'h000E00FF);
    rdx(SDS_OFS_STAT, 32'h00010002);
    wb(1'b1, SDS_OFS_MODE, 32'h00000003);
    xfer(32'h000B1234);
    xfer(32'h00031234);
    rdx(SDS_OFS_STAT, 32'h0001000B);
    rdx(SDS_OFS_RXD, 32'h000BFFFF);
    rdx(SDS_OFS_STAT, 32'h00010002);
    xfer(32'h00071234);
    rdx(SDS_OFS_RXD, 32'h00077FFF);
    // decoded select, prescaler, loopback; csr1 cleared so idle level stays low
    wb(1'b1, SDS_OFS_CSR0 + 9'h004, 32'h00000000);
    wb(1'b1, SDS_OFS_MODE, 32'h0000008F);
    xfer(32'h0008C3A5);
    rdx(SDS_OFS_RXD, 32'h0008C3A5);
    wb(1'b1, SDS_OFS_CSR0, 32'h00000203);
    xfer(32'h000000C3);
    rdx(SDS_OFS_RXD, 32'h000000C3);
    chk({31'h0, pin_out.sclk}, 32'h00000001);
    fault <= 1'b1;
    for (k = 0; k < 50 && irq !== 1'b1; k++) @(posedge clk_i);
    chk({31'h0, irq}, 32'h00000001);
    fault <= 1'b0;
    rdx(SDS_OFS_STAT, 32'h00000004);
    rdx(SDS_OFS_STAT, 32'h00000000);
    rstn_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    rstn_i <= 1'b1;
    rdx(SDS_OFS_STAT, 32'h000000F0);
    rdx(SDS_OFS_IMSK, 32'h00000000);
    rdx(SDS_OFS_TXD, 32'h00000000);
    end_of_test();
  end
endmodule : testbench
